// ---- hdl/pot_wiper_register_access.sv ----
// bus slave command logic and wiper registers of the digital potentiometer
`timescale 1ns/1ps

// Overview of operation
// - a 7-bit wiper position is decoded to one of 128 tap selects
// - after reset the wiper position is loaded from the stored wiper
// - host reads or writes the wiper directly once selected by register_select
// - wiper writes drop data bit 7; wiper reads return bit 7 as 0
// - slave address, pointer and data bytes of a write are all acknowledged
// - a write with the wiper selected touches only the volatile wiper
// - step mode is start, step type address, pointer 00h, both acknowledged
// - each later bus clock steps the wiper up on data high, down on low
// - stop after stepping returns to standby keeping the last position
// - stepping saturates at the minimum and maximum positions
// - a read uses pointer 00h, repeated start, read address, one returned byte
// - reading the stored wiper never alters the wiper position
// - stored wiper keeps 7 bits and reads bit 7 as 0
// - writing the stored wiper starts a store lasting up to 5 ms
// - during the store the bus is ignored and the data line released
// - a stored wiper write updates both registers, then standby
// - address bits 2:1 must match the select pins; bit 0 set means read
// - register_select is write only; reads of it are never issued
// - the slave address is not acknowledged while the store runs
module pot_wiper_register_access #(
  parameter int                                STORE_CYCLES   =
    pot_wiper_pkg::STORE_CYCLES_DEF,
  // type identifiers: arbitrary values, set to suit the system
  parameter logic [4:0]                        TYPE_ID_DIRECT = 5'h12,
  parameter logic [4:0]                        TYPE_ID_STEP   = 5'h13,
  parameter logic [pot_wiper_pkg::WIPER_W-1:0] STORED_INIT    = pot_wiper_pkg::WIPER_MID
) (
  input  wire logic                                  clk_in,
  input  wire logic                                  resetn_in,
  input  wire logic                                  scl_in,
  input  wire logic                                  sda_in,
  input  wire logic                                  addr_select_hi_in,
  input  wire logic                                  addr_select_lo_in,
  output logic                                       sda_out,
  output logic                                       sda_oe_out,
  output logic [pot_wiper_pkg::WIPER_W-1:0]          wiper_position_out,
  output logic [pot_wiper_pkg::TAP_COUNT-1:0]        tap_select_out,
  output logic                                       store_busy_out
);

  if (STORE_CYCLES < 1 || STORE_CYCLES > (2 ** pot_wiper_pkg::TIMER_W) - 1) begin : g_bad_cycles
    $error("STORE_CYCLES does not fit the store timer");
  end

  // the direct and step commands are told apart only by the type identifier
  if (TYPE_ID_DIRECT == TYPE_ID_STEP) begin : g_same_type
    $error("TYPE_ID_DIRECT and TYPE_ID_STEP must differ");
  end

  // the tap decode assumes one select line for every wiper code
  if (pot_wiper_pkg::TAP_COUNT != 2 ** pot_wiper_pkg::WIPER_W) begin : g_bad_taps
    $error("TAP_COUNT does not match the wiper width");
  end

  localparam logic [pot_wiper_pkg::TIMER_W-1:0] STORE_LOAD =
    pot_wiper_pkg::TIMER_W'(STORE_CYCLES);

  // the wiper comes up at mid scale and takes the stored value one clock later
  localparam pot_wiper_pkg::core_state_type CORE_RESET = '{
    state:     pot_wiper_pkg::ST_RECALL,
    after_ack: pot_wiper_pkg::ST_IDLE,
    wiper:     pot_wiper_pkg::WIPER_MID,
    stored:    STORED_INIT,
    sel_wiper: 1'b1,
    scl_sync:  2'h3,
    sda_sync:  2'h3,
    scl_prev:  1'b1,
    sda_prev:  1'b1,
    tap:       pot_wiper_pkg::TAP_COUNT'(1'b1) << pot_wiper_pkg::WIPER_MID,
    default:   '0
  };

  function automatic logic [pot_wiper_pkg::TAP_COUNT-1:0] tap_decode(
    input logic [pot_wiper_pkg::WIPER_W-1:0] pos
  );
    logic [pot_wiper_pkg::TAP_COUNT-1:0] onehot;
    onehot = '0;
    onehot[pos] = 1'b1;
    return onehot;
  endfunction

  // one saturating step; the end positions hold rather than wrap
  function automatic logic [pot_wiper_pkg::WIPER_W-1:0] step_wiper(
    input logic [pot_wiper_pkg::WIPER_W-1:0] pos,
    input logic                              up
  );
    logic [pot_wiper_pkg::WIPER_W-1:0] moved;
    moved = pos;
    if (up) begin
      if (pos != pot_wiper_pkg::WIPER_MAX) begin
        moved = pos + pot_wiper_pkg::WIPER_ONE;
      end
    end else if (pos != pot_wiper_pkg::WIPER_MIN) begin
      moved = pos - pot_wiper_pkg::WIPER_ONE;
    end
    return moved;
  endfunction

  // ---------------- bus clock domain ----------------
  // each rising bus clock captures the data line and flips a toggle; the
  // captured bit then holds still for a whole bus period while the toggle crosses
  // only the toggle and the held bit leave this domain
  pot_wiper_pkg::link_state_type link_reg;
  pot_wiper_pkg::link_state_type link_next;

  always_comb begin
    link_next = link_reg;
    link_next.sample_bit = sda_in;
    link_next.sample_tog = ~link_reg.sample_tog;
  end

  always_ff @(posedge scl_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // ---------------- system clock domain ----------------
  pot_wiper_pkg::core_state_type core_reg;
  pot_wiper_pkg::core_state_type core_next;

  logic       scl_high;
  logic       sda_high;
  logic       bit_rise;
  logic       bit_val;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [7:0] byte_in;
  logic       addr_match;
  logic [4:0] type_id;

  assign scl_high = core_reg.scl_sync[1];
  assign sda_high = core_reg.sda_sync[1];
  // the held bit is read only once its toggle has crossed, so it is settled
  assign bit_rise = core_reg.tog_sync[1] ^ core_reg.tog_seen;
  assign bit_val = link_reg.sample_bit;
  assign scl_fall = core_reg.scl_prev & ~scl_high;
  assign bus_start = scl_high & core_reg.scl_prev & core_reg.sda_prev & ~sda_high;
  assign bus_stop = scl_high & core_reg.scl_prev & ~core_reg.sda_prev & sda_high;
  assign byte_in = {core_reg.shift[6:0], bit_val};
  assign type_id = byte_in[pot_wiper_pkg::ADDR_TYPE_MSB:pot_wiper_pkg::ADDR_TYPE_LSB];
  assign addr_match = byte_in[pot_wiper_pkg::ADDR_SEL_MSB:pot_wiper_pkg::ADDR_SEL_LSB]
                      == core_reg.pin_sync2;

  always_comb begin
    core_next = core_reg;
    // pins and bus lines pass two flops before any decision is made on them
    core_next.scl_sync = {core_reg.scl_sync[0], scl_in};
    core_next.sda_sync = {core_reg.sda_sync[0], sda_in};
    core_next.pin_sync1 = {addr_select_hi_in, addr_select_lo_in};
    core_next.pin_sync2 = core_reg.pin_sync1;
    core_next.tog_sync = {core_reg.tog_sync[0], link_reg.sample_tog};
    core_next.tog_seen = core_reg.tog_sync[1];
    core_next.scl_prev = scl_high;
    core_next.sda_prev = sda_high;

    case (core_reg.state)
      pot_wiper_pkg::ST_RECALL: begin
        core_next.wiper = core_reg.stored;
        core_next.state = pot_wiper_pkg::ST_IDLE;
      end
      pot_wiper_pkg::ST_ADDR: begin
        if (bit_rise) begin
          core_next.shift = byte_in;
          core_next.bit_cnt = core_reg.bit_cnt + pot_wiper_pkg::BIT_ONE;
          if (core_reg.bit_cnt == pot_wiper_pkg::BIT_LAST) begin
            core_next.bit_cnt = '0;
            core_next.state = pot_wiper_pkg::ST_ACK;
            if (addr_match && type_id == TYPE_ID_DIRECT && !byte_in[pot_wiper_pkg::ADDR_RW_BIT]) begin
              core_next.step_mode = 1'b0;
              core_next.after_ack = pot_wiper_pkg::ST_REG;
            end else if (addr_match && type_id == TYPE_ID_DIRECT && core_reg.rd_armed) begin
              // the returned byte carries a zero in bit 7 for either register
              core_next.after_ack = pot_wiper_pkg::ST_READ_TX;
              core_next.shift = {1'b0, core_reg.sel_wiper ? core_reg.wiper
                                                          : core_reg.stored};
            end else if (addr_match && type_id == TYPE_ID_STEP && !byte_in[pot_wiper_pkg::ADDR_RW_BIT]) begin
              core_next.step_mode = 1'b1;
              core_next.after_ack = pot_wiper_pkg::ST_REG;
            end else begin
              // a read not preceded by pointer 00h is refused as well
              core_next.state = pot_wiper_pkg::ST_IDLE;
            end
          end
        end
      end
      pot_wiper_pkg::ST_REG: begin
        if (bit_rise) begin
          core_next.shift = byte_in;
          core_next.bit_cnt = core_reg.bit_cnt + pot_wiper_pkg::BIT_ONE;
          if (core_reg.bit_cnt == pot_wiper_pkg::BIT_LAST) begin
            core_next.bit_cnt = '0;
            core_next.state = pot_wiper_pkg::ST_ACK;
            if (byte_in == pot_wiper_pkg::PTR_WIPER) begin
              core_next.rd_armed = 1'b1;
              core_next.target_select = 1'b0;
              core_next.after_ack = core_reg.step_mode ? pot_wiper_pkg::ST_STEP
                                                       : pot_wiper_pkg::ST_DATA;
            end else if (byte_in == pot_wiper_pkg::PTR_SELECT && !core_reg.step_mode) begin
              core_next.target_select = 1'b1;
              core_next.after_ack = pot_wiper_pkg::ST_DATA;
            end else begin
              core_next.state = pot_wiper_pkg::ST_IDLE;
            end
          end
        end
      end
      pot_wiper_pkg::ST_DATA: begin
        if (bit_rise) begin
          core_next.shift = byte_in;
          core_next.bit_cnt = core_reg.bit_cnt + pot_wiper_pkg::BIT_ONE;
          if (core_reg.bit_cnt == pot_wiper_pkg::BIT_LAST) begin
            // held until stop so that the store begins only at the stop
            core_next.bit_cnt = '0;
            core_next.pending = 1'b1;
            core_next.pend_byte = byte_in;
            core_next.state = pot_wiper_pkg::ST_ACK;
            core_next.after_ack = pot_wiper_pkg::ST_WAIT_STOP;
          end
        end
      end
      pot_wiper_pkg::ST_ACK: begin
        // raised at the falling clock after the eighth bit, dropped at the next
        if (scl_fall) begin
          if (!core_reg.ack_drive) begin
            core_next.ack_drive = 1'b1;
            core_next.sda_oe = 1'b1;
          end else begin
            core_next.ack_drive = 1'b0;
            core_next.state = core_reg.after_ack;
            core_next.sda_oe = (core_reg.after_ack == pot_wiper_pkg::ST_READ_TX) &&
                               !core_reg.shift[7];
          end
        end
      end
      pot_wiper_pkg::ST_READ_TX: begin
        // bit 7 is already on the line; each falling clock moves the next one out
        if (bit_rise) begin
          core_next.bit_cnt = core_reg.bit_cnt + pot_wiper_pkg::BIT_ONE;
        end
        if (scl_fall) begin
          if (core_reg.bit_cnt == pot_wiper_pkg::BIT_COUNT) begin
            // no second byte follows: the master ends with a stop
            core_next.sda_oe = 1'b0;
            core_next.state = pot_wiper_pkg::ST_WAIT_STOP;
          end else begin
            core_next.shift = {core_reg.shift[6:0], 1'b0};
            core_next.sda_oe = !core_reg.shift[6];
          end
        end
      end
      pot_wiper_pkg::ST_STEP: begin
        // the bit is taken at the rising clock and applied at the falling one, so the
        // rising clock of a closing stop, with data low, never steps the wiper
        if (bit_rise) begin
          core_next.shift = byte_in;
          core_next.bit_cnt = pot_wiper_pkg::BIT_ONE;
        end
        if (scl_fall && core_reg.bit_cnt == pot_wiper_pkg::BIT_ONE) begin
          core_next.bit_cnt = '0;
          core_next.wiper = step_wiper(core_reg.wiper, core_reg.shift[0]);
        end
      end
      pot_wiper_pkg::ST_STORE: begin
        // no acknowledge can leave this state, so a polling master sees a refusal
        core_next.sda_oe = 1'b0;
        core_next.timer = core_reg.timer - pot_wiper_pkg::TIMER_ONE;
        if (core_reg.timer == pot_wiper_pkg::TIMER_ONE) begin
          core_next.state = pot_wiper_pkg::ST_IDLE;
        end
      end
      default: begin
      end
    endcase

    // bus conditions are seen in every state but recall and the store
    // a start drops a pending write and only a stop commits it, so a cut frame writes nothing
    if (core_reg.state != pot_wiper_pkg::ST_RECALL &&
        core_reg.state != pot_wiper_pkg::ST_STORE) begin
      if (bus_start) begin
        core_next.state = pot_wiper_pkg::ST_ADDR;
        core_next.bit_cnt = '0;
        core_next.ack_drive = 1'b0;
        core_next.sda_oe = 1'b0;
        core_next.pending = 1'b0;
      end else if (bus_stop) begin
        core_next.state = pot_wiper_pkg::ST_IDLE;
        core_next.ack_drive = 1'b0;
        core_next.sda_oe = 1'b0;
        core_next.pending = 1'b0;
        core_next.rd_armed = 1'b0;
        if (core_reg.pending) begin
          if (core_reg.target_select) begin
            if (core_reg.pend_byte == pot_wiper_pkg::SEL_CODE_WIPER) begin
              core_next.sel_wiper = 1'b1;
            end else if (core_reg.pend_byte == pot_wiper_pkg::SEL_CODE_STORED) begin
              core_next.sel_wiper = 1'b0;
            end
          end else if (core_reg.sel_wiper) begin
            core_next.wiper = core_reg.pend_byte[6:0];
          end else begin
            core_next.wiper = core_reg.pend_byte[6:0];
            core_next.stored = core_reg.pend_byte[6:0];
            core_next.timer = STORE_LOAD;
            core_next.state = pot_wiper_pkg::ST_STORE;
          end
        end
      end
    end

    core_next.busy = core_next.state == pot_wiper_pkg::ST_STORE;
    // decoded from the next wiper so that tap select and wiper change together
    core_next.tap = tap_decode(core_next.wiper);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_reg <= CORE_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  assign sda_out = core_reg.sda_level;
  assign sda_oe_out = core_reg.sda_oe;
  assign wiper_position_out = core_reg.wiper;
  assign tap_select_out = core_reg.tap;
  assign store_busy_out = core_reg.busy;

endmodule

// ---- hdl/pot_wiper_pkg.sv ----
// shared constants, states and state records of the wiper register access block
package pot_wiper_pkg;

  localparam int WIPER_W = 7;
  localparam int TAP_COUNT = 128;
  localparam int TIMER_W = 18;

  // nonvolatile store time and the clock rate that turns it into cycles
  localparam int STORE_TIME_US = 5000;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int STORE_CYCLES_DEF = STORE_TIME_US * CLK_FREQ_MHZ;

  // register pointer bytes and access-select codes
  localparam logic [7:0] PTR_WIPER = 8'h00;
  localparam logic [7:0] PTR_SELECT = 8'h02;
  localparam logic [7:0] SEL_CODE_WIPER = 8'h80;
  localparam logic [7:0] SEL_CODE_STORED = 8'h00;

  // wiper limits and power-up position
  localparam logic [WIPER_W-1:0] WIPER_MIN = 7'h00;
  localparam logic [WIPER_W-1:0] WIPER_MAX = 7'h7F;
  localparam logic [WIPER_W-1:0] WIPER_MID = 7'h40;
  localparam logic [WIPER_W-1:0] WIPER_ONE = 7'h01;

  // slave address byte layout
  localparam int ADDR_RW_BIT = 0;
  localparam int ADDR_SEL_LSB = 1;
  localparam int ADDR_SEL_MSB = 2;
  localparam int ADDR_TYPE_LSB = 3;
  localparam int ADDR_TYPE_MSB = 7;

  // bit counting within a byte
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 18'h0_0001;

  typedef enum logic [3:0] {
    ST_RECALL    = 4'h0,
    ST_IDLE      = 4'h1,
    ST_ADDR      = 4'h3,
    ST_ACK       = 4'h2,
    ST_REG       = 4'h6,
    ST_DATA      = 4'h7,
    ST_WAIT_STOP = 4'h5,
    ST_READ_TX   = 4'h4,
    ST_STEP      = 4'hC,
    ST_STORE     = 4'hD
  } ctrl_state_type;

  // logic clocked by the bus clock itself
  typedef struct packed {
    logic sample_bit;
    logic sample_tog;
  } link_state_type;

  typedef struct packed {
    ctrl_state_type       state;
    ctrl_state_type       after_ack;
    logic [3:0]           bit_cnt;
    logic [7:0]           shift;
    logic                 ack_drive;
    logic                 step_mode;
    logic                 rd_armed;
    logic                 target_select;
    logic                 sel_wiper;
    logic                 pending;
    logic [7:0]           pend_byte;
    logic [WIPER_W-1:0]   wiper;
    logic [WIPER_W-1:0]   stored;
    logic [TIMER_W-1:0]   timer;
    logic                 sda_oe;
    logic                 sda_level;
    logic                 busy;
    logic [TAP_COUNT-1:0] tap;
    logic [1:0]           scl_sync;
    logic [1:0]           sda_sync;
    logic [1:0]           pin_sync1;
    logic [1:0]           pin_sync2;
    logic [1:0]           tog_sync;
    logic                 tog_seen;
    logic                 scl_prev;
    logic                 sda_prev;
  } core_state_type;

endpackage

// ---- verification/pot_wiper_register_access_assertions.sv ----
// checker on the ports of the wiper register access block
`timescale 1ns/1ps
module pot_wiper_checker #(
  parameter int STORE_CYCLES = 50
) (
  input wire logic         clk_in,
  input wire logic         resetn_in,
  input wire logic         scl_in,
  input wire logic         sda_in,
  input wire logic         addr_select_hi_in,
  input wire logic         addr_select_lo_in,
  input wire logic         sda_out,
  input wire logic         sda_oe_out,
  input wire logic [6:0]   wiper_position_out,
  input wire logic [127:0] tap_select_out,
  input wire logic         store_busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [17:0] busy_cnt_reg;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) busy_cnt_reg <= 18'h0_0000;
    else busy_cnt_reg <= store_busy_out ? busy_cnt_reg + 18'h0_0001 : 18'h0_0000;
  end
  tap_onehot_a: assert property ($onehot(tap_select_out))
    else $error("tap select not one-hot");
  tap_decode_a: assert property ($stable(wiper_position_out) |->
    tap_select_out == ({{127{1'b0}}, 1'b1} << wiper_position_out))
    else $error("tap select does not match wiper");
  open_drain_a: assert property (sda_oe_out |-> sda_out == 1'b0)
    else $error("data line driven high");
  busy_quiet_a: assert property (store_busy_out |-> !sda_oe_out)
    else $error("data line driven during store");
  busy_hold_a: assert property (store_busy_out && $past(store_busy_out) |->
    $stable(wiper_position_out))
    else $error("wiper moved during store");
  busy_length_a: assert property ($fell(store_busy_out) |->
    busy_cnt_reg == STORE_CYCLES)
    else $error("store length wrong");
  busy_start_a: assert property ($rose(store_busy_out) |-> scl_in && sda_in)
    else $error("store started outside a stop");
  oe_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in))
    else $error("data line changed while bus clock high");
  wiper_cause_a: assert property ($changed(wiper_position_out) |-> $past(scl_in, 2) ||
    $past(scl_in, 3) || $past(scl_in, 4) || $past(scl_in, 5))
    else $error("wiper changed without bus clock high");
endmodule
bind pot_wiper_register_access pot_wiper_checker #(.STORE_CYCLES(STORE_CYCLES)) chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
  .addr_select_hi_in(addr_select_hi_in), .addr_select_lo_in(addr_select_lo_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .wiper_position_out(wiper_position_out),
  .tap_select_out(tap_select_out), .store_busy_out(store_busy_out));

// ---- verification/bus_master_model.sv ----
// bus master model driving the bus clock and pulling the data line
`timescale 1ns/1ps
module bus_master_model (
  output logic     scl_out,
  output logic     sda_low_out,
  input wire logic sda_in
);
  // quarter of a bit time; phases kept long enough for the slave's synchronisers
  localparam time Q = 50;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic start();
    sda_low_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b0;
    #(2 * Q);
  endtask
  // data changes only while the bus clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    #Q scl_out = 1'b1;
    #Q r = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(1'b1, r);
  endtask
endmodule

// ---- verification/pot_wiper_register_access_bench.sv ----
// self-checking bench of the wiper register access block
`timescale 1ns/1ps
module pot_wiper_register_access_bench;
  // type identifiers are arbitrary values
  localparam logic [4:0] T_DIR = 5'h0C;
  localparam logic [4:0] T_STP = 5'h0D;
  localparam int         LIMIT = 30000;
  logic         clk_in;
  logic         resetn_in;
  logic         scl;
  logic         sda_low;
  logic         sda_in;
  logic         hi_pin;
  logic         lo_pin;
  logic         sda_out;
  logic         sda_oe_out;
  logic [6:0]   wiper;
  logic [127:0] tap;
  logic         busy;
  int           err_count;
  int           checked;
  int           cycles;
  // wired-AND with pull-up
  assign sda_in = !(sda_low || (sda_oe_out && !sda_out));
  bus_master_model bm (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_in));
  pot_wiper_register_access #(.STORE_CYCLES(50), .TYPE_ID_DIRECT(T_DIR),
    .TYPE_ID_STEP(T_STP), .STORED_INIT(7'h2A)) dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_in),
    .addr_select_hi_in(hi_pin), .addr_select_lo_in(lo_pin), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .wiper_position_out(wiper), .tap_select_out(tap),
    .store_busy_out(busy));
  initial begin
    clk_in = 1'b0;
    #7;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: acks %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_tap(input logic [127:0] got, input int pos);
    checked++;
    if (got !== ({{127{1'b0}}, 1'b1} << pos)) begin
      err_count++;
      $display("unexpected at %0t: tap select wrong for %0d", $time, pos);
    end
  endtask
  function automatic logic [7:0] adr(input logic [4:0] t, input logic rw);
    return {t, 2'b10, rw};
  endfunction
  // leaves off the clock edge so that every bus edge that follows stays off it too
  task automatic settle();
    repeat (10) @(posedge clk_in);
    #5;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [2:0] a;
    bm.start();
    bm.wbyte(adr(T_DIR, 1'b0), a[2]);
    bm.wbyte(ptr, a[1]);
    bm.wbyte(d, a[0]);
    bm.stop();
    settle();
    chk_ack(a, 3'b111);
  endtask
  // only pointer 00h is ever read back
  task automatic rd(output logic [7:0] d);
    logic [2:0] a;
    bm.start();
    bm.wbyte(adr(T_DIR, 1'b0), a[2]);
    bm.wbyte(8'h00, a[1]);
    bm.start();
    bm.wbyte(adr(T_DIR, 1'b1), a[0]);
    bm.rbyte(d);
    bm.stop();
    settle();
    chk_ack(a, 3'b111);
  endtask
  task automatic step(input logic [3:0] bits, input int n);
    logic [2:0] a;
    logic       r;
    a[0] = 1'b1;
    bm.start();
    bm.wbyte(adr(T_STP, 1'b0), a[2]);
    bm.wbyte(8'h00, a[1]);
    for (int i = n - 1; i >= 0; i--) bm.bit_io(bits[i], r);
    bm.stop();
    settle();
    chk_ack(a, 3'b111);
  endtask
  task automatic test_reset();
    chk_byte({1'b0, wiper}, 8'h2A);
    chk_tap(tap, 42);
  endtask
  task automatic test_wiper();
    logic [7:0] d;
    wr(8'h02, 8'h80);
    wr(8'h00, 8'hC5);
    chk_byte({1'b0, wiper}, 8'h45);
    chk_tap(tap, 69);
    rd(d);
    chk_byte(d, 8'h45);
  endtask
  task automatic test_step();
    wr(8'h00, 8'h7E);
    step(4'b0111, 3);
    chk_byte({1'b0, wiper}, 8'h7F);
    step(4'b0000, 2);
    chk_byte({1'b0, wiper}, 8'h7D);
    wr(8'h00, 8'h01);
    step(4'b0100, 3);
    chk_byte({1'b0, wiper}, 8'h00);
  endtask
  task automatic test_refuse();
    logic [2:0] a;
    bm.start();
    bm.wbyte({T_DIR, 2'b01, 1'b0}, a[2]);
    bm.wbyte(8'h00, a[1]);
    bm.wbyte(8'h33, a[0]);
    bm.stop();
    chk_ack(a, 3'b000);
    bm.start();
    bm.wbyte(adr(5'h1F, 1'b0), a[2]);
    bm.stop();
    bm.start();
    bm.wbyte(adr(T_DIR, 1'b0), a[1]);
    bm.wbyte(8'h05, a[0]);
    bm.wbyte(8'h33, a[0]);
    bm.stop();
    settle();
    chk_ack(a, 3'b010);
    chk_byte({1'b0, wiper}, 8'h00);
  endtask
  task automatic test_store();
    logic       a;
    logic [7:0] d;
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h99);
    chk_ack({2'b00, busy}, 3'b001);
    bm.start();
    bm.wbyte(adr(T_DIR, 1'b0), a);
    bm.stop();
    chk_ack({2'b00, a}, 3'b000);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk_in);
    settle();
    chk_ack({2'b00, busy}, 3'b000);
    chk_byte({1'b0, wiper}, 8'h19);
    rd(d);
    chk_byte(d, 8'h19);
    chk_byte({1'b0, wiper}, 8'h19);
  endtask
  initial begin
    resetn_in = 1'b0;
    hi_pin = 1'b1;
    lo_pin = 1'b0;
    err_count = 0;
    checked = 0;
    cycles = 0;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    settle();
    test_reset();
    test_wiper();
    test_step();
    test_refuse();
    test_store();
    finish_test();
  end
endmodule
